/* rtl/data_space_paging_eeprom_ctrl.v */
// data-space paging, rom window and nvm controller
`timescale 1ns/1ps
`include "paging_regs.vh"
module data_space_paging_eeprom_ctrl #(
  parameter [31:0] PROGRAM_CYCLES = `PROGRAM_CYCLES // programming length in clocks
) (
  input wire clk, // core clock, 20 MHz
  input wire srst, // synchronous reset, active high
  input wire ce, // clock enable, freezes state when low
  input wire [7:0] cpu_addr, // data-space address
  input wire cpu_rd, // read strobe, one cycle
  input wire cpu_wr, // write strobe, one cycle
  input wire [7:0] cpu_wdata, // write data
  output reg [7:0] cpu_rdata, // read data, one cycle after strobe
  output reg cpu_rvalid, // read data valid pulse
  output reg cpu_sel_ext, // this block answered the read
  output reg [12:0] pm_addr, // program memory address
  output reg pm_rd, // program memory read strobe
  input wire [7:0] pm_rdata, // program memory data, same cycle
  output reg [6:0] nvm_addr, // nvm array address, page and offset
  output reg [7:0] nvm_wdata, // nvm array write data
  output reg nvm_wr, // nvm array write strobe
  output reg nvm_rd, // nvm array read strobe
  input wire [7:0] nvm_rdata, // nvm array read data, same cycle
  output reg nvm_power_down, // nvm standby level
  output reg [6:0] ram_addr, // extra ram address, page and offset
  output reg [7:0] ram_wdata, // extra ram write data
  output reg ram_wr, // extra ram write strobe
  output reg ram_rd, // extra ram read strobe
  input wire [7:0] ram_rdata, // extra ram read data, same cycle
  output reg program_busy // busy level
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  // software-visible registers
  reg [6:0] rom_window_base;
  reg [7:0] low_bank_select;
  reg program_enable;
  reg row_mode_enable;
  reg row_program_start;
  reg nvm_standby;
  // sequencer and row state
  reg row_locked;
  reg [2:0] row_addr;
  reg nvm_page;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] slot;
  reg [7:0] byte_data;
  reg [5:0] byte_addr;
  wire [7:0] latch_data [0:`ROW_BYTES-1];
  wire [`ROW_BYTES-1:0] latch_written;
  wire timer_running;
  wire timer_done;

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BYTE = 3'b010;
  localparam [2:0] ST_ROW = 3'b100;
  // reset image of the control register
  wire [7:0] ctl_reset = `NVM_CONTROL_RESET;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // window and bank regions
  wire in_window = (cpu_addr >= `WIN_LO) && (cpu_addr <= `WIN_HI);
  wire in_bank = (cpu_addr <= `BANK_HI);
  // bank select bits
  wire sel_nvm0 = low_bank_select[`BIT_NVM_PAGE0];
  wire sel_nvm1 = low_bank_select[`BIT_NVM_PAGE1];
  wire sel_ram1 = low_bank_select[`BIT_RAM_PAGE1];
  wire sel_ram2 = low_bank_select[`BIT_RAM_PAGE2];
  wire sel_nvm = sel_nvm0 | sel_nvm1;
  wire sel_ram = sel_ram1 | sel_ram2;
  wire busy = (state != ST_IDLE);
  // nvm reachable only selected, awake and idle
  wire nvm_ok = in_bank && sel_nvm && !nvm_standby && !busy;
  wire row_hit = !row_locked || (cpu_addr[5:3] == row_addr);
  // one-hot latch slot of the current address
  wire [`ROW_BYTES-1:0] slot_hit = {{(`ROW_BYTES-1){1'b0}}, 1'b1} << cpu_addr[2:0];
  // control register writes
  wire wr_ctl = cpu_wr && (cpu_addr == `ADDR_NVM_CONTROL);
  wire ctl_ok = wr_ctl && !busy;
  wire set_row_mode = ctl_ok && cpu_wdata[`BIT_ROW_MODE] && !row_mode_enable;
  // start needs enable and row mode already set
  wire start_row = ctl_ok && cpu_wdata[`BIT_ROW_START] && program_enable && row_mode_enable;
  // nvm array writes
  wire nvm_write = cpu_wr && nvm_ok && program_enable;
  wire byte_write = nvm_write && !row_mode_enable;
  wire row_write = nvm_write && row_mode_enable && row_hit;

  // ------------------------------------------------------------
  // row latches
  // ------------------------------------------------------------
  // one latch per byte of the row
  genvar gi;
  generate
    for (gi = 0; gi < `ROW_BYTES; gi = gi + 1) begin : g_latch
      row_latch u_latch (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .clear(set_row_mode),
        .load(row_write && slot_hit[gi]),
        .din(cpu_wdata),
        .data(latch_data[gi]),
        .written(latch_written[gi])
      );
    end
  endgenerate

  // one timer paces both byte and row cycles
  program_timer #(
    .CYCLES(PROGRAM_CYCLES)
  ) u_timer (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .start((state == ST_IDLE) && (byte_write || start_row)),
    .running(timer_running),
    .done(timer_done)
  );

  // ------------------------------------------------------------
  // programming state machine
  // ------------------------------------------------------------
  // next state from start requests and timer end
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_row) begin
          next_state = ST_ROW;
        end else if (byte_write) begin
          next_state = ST_BYTE;
        end
      end
      ST_BYTE: begin
        // hold one clock past the timer so busy covers the commit
        if (!timer_running && !timer_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_ROW: begin
        if (timer_done && (slot == `ROW_LAST)) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state, control bits and row lock
  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      program_enable <= ctl_reset[`BIT_PROGRAM_ENABLE];
      row_mode_enable <= ctl_reset[`BIT_ROW_MODE];
      row_program_start <= ctl_reset[`BIT_ROW_START];
      nvm_standby <= ctl_reset[`BIT_STANDBY];
      row_locked <= 1'b0;
      row_addr <= 3'h0;
      nvm_page <= 1'b0;
      byte_data <= 8'h00;
      byte_addr <= 6'h00;
    end else if (ce) begin
      state <= next_state;
      if (ctl_ok) begin
        // control writes only while idle
        program_enable <= cpu_wdata[`BIT_PROGRAM_ENABLE];
        nvm_standby <= cpu_wdata[`BIT_STANDBY];
        row_mode_enable <= cpu_wdata[`BIT_ROW_MODE];
        if (start_row) begin
          row_program_start <= 1'b1;
        end
        if (!cpu_wdata[`BIT_ROW_MODE]) begin
          row_locked <= 1'b0;
        end
      end
      // first row write locks the row and page
      if (row_write && !row_locked) begin
        row_locked <= 1'b1;
        row_addr <= cpu_addr[5:3];
        nvm_page <= sel_nvm1;
      end
      // byte mode keeps address and data for the commit
      if (byte_write && (state == ST_IDLE)) begin
        byte_data <= cpu_wdata;
        byte_addr <= cpu_addr[5:0];
        nvm_page <= sel_nvm1;
      end
      // end of cycle drops row mode, start and lock
      if ((state != ST_IDLE) && (next_state == ST_IDLE)) begin
        row_program_start <= 1'b0;
        row_mode_enable <= 1'b0;
        row_locked <= 1'b0;
      end
    end
  end

  // row slot walker: one written slot committed per clock during the cycle
  always @(posedge clk) begin
    if (srst) begin
      slot <= 3'h0;
    end else if (ce) begin
      if (state != ST_ROW) begin
        slot <= 3'h0;
      end else if (slot != `ROW_LAST) begin
        slot <= slot + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // window base and bank select
  // ------------------------------------------------------------
  // no reset: both are undefined until software loads them
  always @(posedge clk) begin
    if (ce && cpu_wr && (cpu_addr == `ADDR_WINDOW_BASE)) begin
      rom_window_base <= cpu_wdata[6:0];
    end
    if (ce && cpu_wr && (cpu_addr == `ADDR_BANK_SELECT)) begin
      low_bank_select <= cpu_wdata;
    end
  end

  // ------------------------------------------------------------
  // status outputs and readback
  // ------------------------------------------------------------
  // standby level and busy flag follow the control state
  always @(posedge clk) begin
    if (srst) begin
      nvm_power_down <= ctl_reset[`BIT_STANDBY];
      program_busy <= ctl_reset[`BIT_PROGRAM_BUSY];
    end else if (ce) begin
      nvm_power_down <= nvm_standby;
      program_busy <= (next_state != ST_IDLE);
    end
  end

  // status word: only busy reads back, write-only bits read as zero
  reg [7:0] ctl_status;
  always @* begin
    ctl_status = 8'h00;
    ctl_status[`BIT_PROGRAM_BUSY] = busy;
  end

  // ------------------------------------------------------------
  // array strobes and read path
  // ------------------------------------------------------------
  // all outputs registered; reads answer one clock after the strobe
  always @(posedge clk) begin
    if (srst) begin
      cpu_rdata <= 8'h00;
      cpu_rvalid <= 1'b0;
      cpu_sel_ext <= 1'b0;
      pm_addr <= 13'h0000;
      pm_rd <= 1'b0;
      nvm_addr <= 7'h00;
      nvm_wdata <= 8'h00;
      nvm_wr <= 1'b0;
      nvm_rd <= 1'b0;
      ram_addr <= 7'h00;
      ram_wdata <= 8'h00;
      ram_wr <= 1'b0;
      ram_rd <= 1'b0;
    end else if (ce) begin
      cpu_rvalid <= cpu_rd;
      cpu_sel_ext <= 1'b0;
      cpu_rdata <= 8'h00;
      pm_rd <= 1'b0;
      nvm_rd <= 1'b0;
      nvm_wr <= 1'b0;
      ram_rd <= 1'b0;
      ram_wr <= 1'b0;
      // reads: window first, then ram bank, nvm, status
      if (cpu_rd && in_window) begin
        pm_addr <= {rom_window_base[6:0], cpu_addr[5:0]};
        pm_rd <= 1'b1;
        cpu_rdata <= pm_rdata;
        cpu_sel_ext <= 1'b1;
      end else if (cpu_rd && in_bank && sel_ram) begin
        ram_addr <= {sel_ram2, cpu_addr[5:0]};
        ram_rd <= 1'b1;
        cpu_rdata <= ram_rdata;
        cpu_sel_ext <= 1'b1;
      end else if (cpu_rd && nvm_ok && !row_mode_enable) begin
        nvm_addr <= {sel_nvm1, cpu_addr[5:0]};
        nvm_rd <= 1'b1;
        cpu_rdata <= nvm_rdata;
        cpu_sel_ext <= 1'b1;
      end else if (cpu_rd && (cpu_addr == `ADDR_NVM_CONTROL)) begin
        cpu_rdata <= ctl_status;
        cpu_sel_ext <= 1'b1;
      end
      // ram bank writes pass straight through
      if (cpu_wr && in_bank && sel_ram) begin
        ram_addr <= {sel_ram2, cpu_addr[5:0]};
        ram_wdata <= cpu_wdata;
        ram_wr <= 1'b1;
      end
      // byte commit at the timer end, row commits slot by slot
      if (state == ST_BYTE && timer_done) begin
        nvm_addr <= {nvm_page, byte_addr};
        nvm_wdata <= byte_data;
        nvm_wr <= 1'b1;
      end
      if (state == ST_ROW && timer_running && latch_written[slot]) begin
        nvm_addr <= {nvm_page, row_addr, slot};
        nvm_wdata <= latch_data[slot];
        nvm_wr <= 1'b1;
      end
    end
  end
endmodule

/* rtl/paging_regs.vh */
// register offsets, field positions and timing constants for the paging and nvm block
`ifndef PAGING_REGS_VH
`define PAGING_REGS_VH
`define ADDR_WINDOW_BASE 8'hC9
`define ADDR_BANK_SELECT 8'hCB
`define ADDR_NVM_CONTROL 8'hDF
`define NVM_CONTROL_RESET 8'h00
`define WIN_LO 8'h40
`define WIN_HI 8'h7F
`define BANK_HI 8'h3F
`define BIT_PROGRAM_ENABLE 0
`define BIT_PROGRAM_BUSY 1
`define BIT_ROW_MODE 2
`define BIT_ROW_START 3
`define BIT_STANDBY 6
`define BIT_NVM_PAGE0 0
`define BIT_NVM_PAGE1 1
`define BIT_RAM_PAGE1 3
`define BIT_RAM_PAGE2 4
`define PROGRAM_TIME_NS 32'd5000000
`define CLK_PERIOD_NS 32'd50
`define PROGRAM_CYCLES (`PROGRAM_TIME_NS / `CLK_PERIOD_NS)
`define ROW_BYTES 8
`define ROW_LAST 3'h7
`endif

/* rtl/program_timer.v */
// programming cycle length counter
`timescale 1ns/1ps
module program_timer #(
  parameter [31:0] CYCLES = 32'd100000 // programming cycle length in clocks
) (
  input wire clk, // core clock
  input wire srst, // synchronous reset
  input wire ce, // clock enable
  input wire start, // begin counting
  output reg running, // cycle in progress
  output reg done // one-cycle pulse at end
);
  reg [31:0] count;
  // load on start, count down, pulse done on zero
  always @(posedge clk) begin
    if (srst) begin
      count <= 32'h00000000;
      running <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !running) begin
        count <= CYCLES - 32'h00000001;
        running <= 1'b1;
      end else if (running) begin
        if (count == 32'h00000000) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 32'h00000001;
        end
      end
    end
  end
endmodule

/* rtl/row_latch.v */
// one volatile row latch: data byte plus written flag
`timescale 1ns/1ps
module row_latch (
  input wire clk, // core clock
  input wire srst, // synchronous reset
  input wire ce, // clock enable
  input wire clear, // clear written flag
  input wire load, // capture byte
  input wire [7:0] din, // byte to capture
  output reg [7:0] data, // held byte
  output reg written // byte was loaded since clear
);
  // capture and flag; load wins over clear
  always @(posedge clk) begin
    if (srst) begin
      data <= 8'h00;
      written <= 1'b0;
    end else if (ce) begin
      if (load) begin
        data <= din;
        written <= 1'b1;
      end else if (clear) begin
        written <= 1'b0;
      end
    end
  end
endmodule

/* verification/data_space_paging_eeprom_ctrl_test.sv */
// self-checking bench for the paging and nvm controller
`timescale 1ns/1ps
module data_space_paging_eeprom_ctrl_test;
  logic clk, srst, ce, cpu_rd, cpu_wr, cpu_rvalid, cpu_sel_ext, pm_rd, nvm_wr, nvm_rd, nvm_power_down;
  logic ram_wr, ram_rd, program_busy;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, pm_rdata, nvm_rdata, nvm_wdata, ram_rdata, ram_wdata, sp, sn, sr, d, b;
  logic [12:0] pm_addr;
  logic [6:0] nvm_addr, ram_addr;
  logic [7:0] ex_nvm [128];
  logic [7:0] ex_ram [128];
  logic [7:0] rowq [$];
  int errors, checks_done, cycles, i, k;
  data_space_paging_eeprom_ctrl #(.PROGRAM_CYCLES(32'd16)) u_data_space_paging_eeprom_ctrl (
    .clk(clk), .srst(srst), .ce(ce), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .cpu_sel_ext(cpu_sel_ext),
    .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
    .nvm_wr(nvm_wr), .nvm_rd(nvm_rd), .nvm_rdata(nvm_rdata), .nvm_power_down(nvm_power_down),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_wr(ram_wr), .ram_rd(ram_rd), .ram_rdata(ram_rdata),
    .program_busy(program_busy));
  mem_side_model u_mem_side_model (
    .clk(clk), .nvm_wr(nvm_wr), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .ram_wr(ram_wr),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .pm_rdata(pm_rdata), .nvm_rdata(nvm_rdata),
    .ram_rdata(ram_rdata));
  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= v;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    #1;
    sp = pm_rdata;
    sn = nvm_rdata;
    sr = ram_rdata;
    @(posedge clk);
    cpu_rd <= 1'b0;
    #1;
  endtask
  task automatic wait_idle;
    k = 0;
    while (program_busy === 1'b1 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {srst, ce, cpu_rd, cpu_wr, cpu_addr, cpu_wdata} = {3'b110, 17'h0};
    {errors, checks_done, cycles} = 0;
    for (i = 0; i < 128; i++) begin
      ex_nvm[i] = 8'hFF;
      ex_ram[i] = 8'h00;
    end
    k = $urandom(32'h04D3);
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(8'hDF);
    chk(cpu_rdata, 8'h00);
    rd(8'hC9);
    chk({cpu_sel_ext, cpu_rdata}, 9'h000);
    rd(8'hCB);
    chk({cpu_sel_ext, cpu_rdata}, 9'h000);
    $display("reset test ended");
    for (i = 0; i < 4; i++) begin
      b = (i == 0) ? 8'h7F : $urandom;
      d = (i == 0) ? 8'h7F : (8'h40 | ($urandom & 8'h3F));
      wr(8'hC9, b);
      rd(d);
      chk({pm_rd, cpu_rdata}, {1'b1, sp});
      chk(pm_addr, {b[6:0], d[5:0]});
    end
    $display("window test ended");
    for (i = 0; i < 2; i++) begin
      wr(8'hCB, i ? 8'h10 : 8'h08);
      d = $urandom;
      b = $urandom & 8'h3F;
      wr(b, d);
      ex_ram[{i[0], b[5:0]}] = d;
      rd(b);
      chk({ram_rd, cpu_sel_ext, cpu_rdata}, {2'b11, sr});
      chk(u_mem_side_model.ram_mem[{i[0], b[5:0]}], ex_ram[{i[0], b[5:0]}]);
    end
    wr(8'hCB, 8'h00);
    rd(8'h10);
    chk({ram_rd, nvm_rd, cpu_sel_ext}, 3'b000);
    $display("bank test ended");
    wr(8'hCB, 8'h01);
    wr(8'hDF, 8'h40);
    rd(8'h05);
    chk({nvm_rd, cpu_sel_ext, nvm_power_down}, 3'b001);
    wr(8'hDF, 8'h00);
    rd(8'h05);
    chk({nvm_rd, cpu_sel_ext, cpu_rdata}, {2'b11, sn});
    d = $urandom;
    wr(8'h12, d);
    chk(program_busy, 1'b0);
    wr(8'hDF, 8'h01);
    wr(8'h12, d);
    chk(program_busy, 1'b1);
    ex_nvm[8'h12] = d;
    rd(8'hDF);
    chk(cpu_rdata, 8'h02);
    wr(8'hDF, 8'h40);
    wr(8'h13, ~d);
    rd(8'h12);
    chk({nvm_rd, nvm_power_down}, 2'b00);
    wait_idle();
    chk(program_busy, 1'b0);
    chk(u_mem_side_model.nvm_mem[8'h12], ex_nvm[8'h12]);
    chk(u_mem_side_model.nvm_mem[8'h13], ex_nvm[8'h13]);
    $display("byte test ended");
    wr(8'hCB, 8'h02);
    wr(8'hDF, 8'h09);
    chk(program_busy, 1'b0);
    wr(8'hDF, 8'h05);
    rowq = '{8'h18, 8'h1A, 8'h1B};
    foreach (rowq[j]) begin
      d = $urandom;
      wr(rowq[j], d);
      ex_nvm[8'h40 | rowq[j]] = d;
    end
    wr(8'h20, 8'h00);
    wr(8'hDF, 8'h0D);
    chk(program_busy, 1'b1);
    wait_idle();
    chk(program_busy, 1'b0);
    for (i = 8'h58; i < 8'h61; i++)
      chk(u_mem_side_model.nvm_mem[i], ex_nvm[i]);
    wr(8'hDF, 8'h09);
    chk(program_busy, 1'b0);
    $display("row test ended");
    test_done();
  end
endmodule

/* verification/mem_side_model.sv */
// program memory, nvm array and extra ram behind the block
`timescale 1ns/1ps
module mem_side_model (
  input wire logic clk, // core clock
  input wire logic nvm_wr, // nvm commit
  input wire logic [6:0] nvm_addr, // nvm address
  input wire logic [7:0] nvm_wdata, // nvm data
  input wire logic ram_wr, // ram write
  input wire logic [6:0] ram_addr, // ram address
  input wire logic [7:0] ram_wdata, // ram data
  output logic [7:0] pm_rdata, // program data
  output logic [7:0] nvm_rdata, // nvm data
  output logic [7:0] ram_rdata // ram data
);
  logic [7:0] nvm_mem [128];
  logic [7:0] ram_mem [128];
  logic [7:0] cnt;
  // nvm cells start virgin
  initial begin
    cnt = 8'h00;
    for (int j = 0; j < 128; j++) begin
      nvm_mem[j] = 8'hFF;
      ram_mem[j] = 8'h00;
    end
  end
  // store writes; read lines change every cycle
  always @(posedge clk) begin
    cnt <= cnt + 8'h3B;
    if (nvm_wr)
      nvm_mem[nvm_addr] <= nvm_wdata;
    if (ram_wr)
      ram_mem[ram_addr] <= ram_wdata;
  end
  assign pm_rdata = cnt;
  assign nvm_rdata = cnt ^ 8'h5A;
  assign ram_rdata = cnt ^ 8'hA5;
endmodule

/* verification/paging_checker.sv */
// port assertions for the paging and nvm controller
`timescale 1ns/1ps
module paging_checker #(
  parameter [31:0] PROGRAM_CYCLES = 32'd16 // programming length
) (
  input wire clk, // core clock
  input wire srst, // sync reset
  input wire ce, // clock enable
  input wire [7:0] cpu_addr, // address
  input wire cpu_rd, // read strobe
  input wire [7:0] cpu_rdata, // read data
  input wire cpu_rvalid, // read valid
  input wire cpu_sel_ext, // block answered
  input wire [12:0] pm_addr, // program address
  input wire pm_rd, // program read
  input wire [7:0] pm_rdata, // program data
  input wire nvm_rd, // nvm read
  input wire nvm_wr, // nvm commit
  input wire nvm_power_down, // standby level
  input wire program_busy // busy level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // busy stays up for a run
  sequence s_busy_run;
    program_busy [*8];
  endsequence
  property p_rd_answer;
    ce && cpu_rd |=> cpu_rvalid;
  endproperty
  property p_window;
    ce && cpu_rd && cpu_addr[7:6] == 2'b01 |=> pm_rd && cpu_sel_ext &&
      {2'b00, pm_addr[5:0]} == ($past(cpu_addr) & 8'h3F) && cpu_rdata == $past(pm_rdata);
  endproperty
  property p_wo_read;
    ce && cpu_rd && (cpu_addr == 8'hC9 || cpu_addr == 8'hCB) |=> cpu_rdata == 8'h00 && !cpu_sel_ext;
  endproperty
  property p_ctl_read;
    ce && cpu_rd && cpu_addr == 8'hDF |=> cpu_rdata == {6'h00, $past(program_busy), 1'b0};
  endproperty
  property p_standby;
    nvm_rd |-> !nvm_power_down;
  endproperty
  property p_busy_read;
    ce && cpu_rd && program_busy && cpu_addr < 8'h40 |=> !nvm_rd;
  endproperty
  property p_commit_busy;
    nvm_wr |-> program_busy;
  endproperty
  property p_busy_run;
    $rose(program_busy) |-> s_busy_run ##[1:40] !program_busy;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_window: assert property (p_window) else $error("window read wrong");
  a_wo_read: assert property (p_wo_read) else $error("write-only register readable");
  a_ctl_read: assert property (p_ctl_read) else $error("control read wrong");
  a_standby: assert property (p_standby) else $error("nvm read in standby");
  a_busy_read: assert property (p_busy_read) else $error("nvm read while busy");
  a_commit_busy: assert property (p_commit_busy) else $error("commit outside busy");
  a_busy_run: assert property (p_busy_run) else $error("busy length wrong");
endmodule
bind data_space_paging_eeprom_ctrl paging_checker #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_paging_checker (
  .clk(clk), .srst(srst), .ce(ce), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
  .cpu_rvalid(cpu_rvalid), .cpu_sel_ext(cpu_sel_ext), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
  .nvm_rd(nvm_rd), .nvm_wr(nvm_wr), .nvm_power_down(nvm_power_down), .program_busy(program_busy));
